/* File: hw/paio_if.sv */
// Purpose: wired-and resolution of the bus lines between processor and peripheral
// Assumes: open-collector lines pull low where a party enables a 0
// Notes:   address, init and grant are driven by the processor only
`timescale 1ns/10ps
interface paio_if;
  import paio_pkg::*;

  logic [ADDR_W-1:0] io_address_lines_n;
  logic              init_n;
  logic              dma_bus_grant_n;
  logic [DATA_W-1:0] cpu_data_o;
  logic [DATA_W-1:0] cpu_data_oe;
  logic [MODE_W-1:0] cpu_mode_o;
  logic [MODE_W-1:0] cpu_mode_oe;
  logic [DATA_W-1:0] dev_data_o;
  logic [DATA_W-1:0] dev_data_oe;
  logic [MODE_W-1:0] dev_mode_o;
  logic [MODE_W-1:0] dev_mode_oe;
  logic              dev_rsp_o;
  logic              dev_rsp_oe;
  logic              dev_req_o;
  logic              dev_req_oe;
  logic [3:0]        dev_irq_o;
  logic [3:0]        dev_irq_oe;
  logic [DATA_W-1:0] io_data_lines_n;
  logic [MODE_W-1:0] mode_lines;
  logic              xfer_response_n;
  logic              dma_bus_request_n;
  logic [3:0]        irq_level_lines_n;

  // a released line floats high, any enabled low drive wins
  assign io_data_lines_n   = (cpu_data_o | ~cpu_data_oe) & (dev_data_o | ~dev_data_oe);
  assign mode_lines        = (cpu_mode_o | ~cpu_mode_oe) & (dev_mode_o | ~dev_mode_oe);
  assign xfer_response_n   = dev_rsp_o | ~dev_rsp_oe;
  assign dma_bus_request_n = dev_req_o | ~dev_req_oe;
  assign irq_level_lines_n = dev_irq_o | ~dev_irq_oe;

  modport cpu (
    output io_address_lines_n, init_n, dma_bus_grant_n,
    output cpu_data_o, cpu_data_oe, cpu_mode_o, cpu_mode_oe,
    input  io_data_lines_n, mode_lines, xfer_response_n, dma_bus_request_n, irq_level_lines_n
  );

  modport dev (
    input  io_address_lines_n, init_n, dma_bus_grant_n,
    output dev_data_o, dev_data_oe, dev_mode_o, dev_mode_oe,
    output dev_rsp_o, dev_rsp_oe, dev_req_o, dev_req_oe, dev_irq_o, dev_irq_oe,
    input  io_data_lines_n, mode_lines, xfer_response_n, dma_bus_request_n, irq_level_lines_n
  );
endinterface : paio_if

/* File: hw/paio_master.sv */
// Purpose: processor end of the bus: fetch/store, dma grant, interrupt poll
// Assumes: bus inputs are asynchronous and pass two flip-flops
// Notes:   one bus cycle at a time; idle arbitration is dma, then poll, then cmd
`timescale 1ns/10ps
module paio_master
  import paio_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              cmd_valid,
  input  wire logic              cmd_write,
  input  wire logic              cmd_byte,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  output logic                   cmd_ready,
  output logic                   rsp_valid,
  output logic                   rsp_err,
  output logic [DATA_W-1:0]      rsp_rdata,
  input  wire logic              end_of_instr,
  input  wire logic              serial_irq_req,
  output logic                   irq_valid,
  output logic                   irq_serial,
  output logic [1:0]             irq_level,
  output logic [2:0]             irq_bit,
  output logic                   dma_active,
  paio_if.cpu                    bus
);

  typedef enum logic [9:0] {
    C_IDLE    = 10'h001,
    C_SETUP   = 10'h002,
    C_WAIT    = 10'h004,
    C_REL     = 10'h008,
    C_DG_SET  = 10'h010,
    C_DG_WAIT = 10'h020,
    C_DG_ADDR = 10'h040,
    C_DG_XFER = 10'h080,
    C_IP_SET  = 10'h100,
    C_IP_WAIT = 10'h200
  } cpu_st_t;

  typedef struct packed {
    cpu_st_t           st;
    logic [CNT_W-1:0]  cnt;
    logic [ADDR_W-1:0] addr_n;
    logic [MODE_W-1:0] mode;
    logic              mode_drv;
    logic [DATA_W-1:0] wdata_n;
    logic              data_drv;
    logic              init_n;
    logic              grant_n;
    logic              is_wr;
    logic              a0;
    logic [DATA_W-1:0] d1;
    logic [DATA_W-1:0] d2;
    logic              r1;
    logic              r2;
    logic              q1;
    logic              q2;
    logic [3:0]        i1;
    logic [3:0]        i2;
    logic              eoi_pend;
    logic              cmd_ready;
    logic              rsp_valid;
    logic              rsp_err;
    logic [DATA_W-1:0] rdata;
    logic              irq_valid;
    logic              irq_serial;
    logic [1:0]        irq_level;
    logic [2:0]        irq_bit;
    logic              dma_active;
  } cpu_reg_t;

  // synchronisers start at the released (high) level so reset shows no request
  localparam cpu_reg_t RST_VAL = '{
    st: C_IDLE, addr_n: '1, wdata_n: '1, init_n: 1'b1, grant_n: 1'b1,
    d1: '1, d2: '1, r1: 1'b1, r2: 1'b1, q1: 1'b1, q2: 1'b1, i1: '1, i2: '1,
    mode: MODE_POLL0, default: '0
  };

  localparam logic [CNT_W-1:0] TIMEOUT_LAST = CNT_W'(STORE_TIMEOUT_CYC - 1);
  localparam logic [CNT_W-1:0] POLL_LAST    = CNT_W'(POLL_WINDOW_CYC - 1);
  localparam logic [CNT_W-1:0] DSET_LAST    = CNT_W'(DMA_SETUP_CYC - 1);

  cpu_reg_t q;
  cpu_reg_t d;

  logic              rsp_s;
  logic              req_s;
  logic [3:0]        irq_s;
  logic [DATA_W-1:0] data_s;

  assign rsp_s  = ~q.r2;
  assign req_s  = ~q.q2;
  assign irq_s  = ~q.i2;
  assign data_s = ~q.d2;

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    d = q;
    d.d1 = bus.io_data_lines_n;
    d.d2 = q.d1;
    d.r1 = bus.xfer_response_n;
    d.r2 = q.r1;
    d.q1 = bus.dma_bus_request_n;
    d.q2 = q.q1;
    d.i1 = bus.irq_level_lines_n;
    d.i2 = q.i1;
    d.rsp_valid = 1'b0;
    d.irq_valid = 1'b0;
    // a new end-of-instruction pulse beats the clear in the same cycle
    d.eoi_pend = q.eoi_pend | end_of_instr;

    case (q.st)
      C_IDLE:
      begin
        if (q.cmd_ready && cmd_valid)
        begin
          d.addr_n   = ~cmd_addr;
          d.mode     = xfer_code(cmd_write, cmd_byte);
          d.mode_drv = 1'b1;
          d.data_drv = cmd_write;
          d.wdata_n  = cmd_byte ? ~{8'h00, cmd_wdata[7:0]} : ~cmd_wdata;
          d.is_wr    = cmd_write;
          d.a0       = cmd_addr[0] & cmd_byte;
          d.rsp_err  = 1'b0;
          d.st       = C_SETUP;
        end
        else if (req_s)
        begin
          d.grant_n    = 1'b0;
          d.mode       = MODE_POLL0;
          d.mode_drv   = 1'b1;
          d.dma_active = 1'b1;
          d.st         = C_DG_SET;
        end
        else if (q.eoi_pend)
        begin
          d.eoi_pend = end_of_instr;
          if (|irq_s)
          begin
            d.irq_level = top_level(irq_s);
            d.mode      = poll_code(top_level(irq_s));
            d.mode_drv  = 1'b1;
            d.st        = C_IP_SET;
          end
          else if (serial_irq_req)
          begin
            d.irq_valid  = 1'b1;
            d.irq_serial = 1'b1;
          end
        end
      end
      C_SETUP:
      begin
        // lines were set up one cycle before init goes active
        d.init_n = 1'b0;
        d.cnt    = '0;
        d.st     = C_WAIT;
      end
      C_WAIT:
      begin
        if (rsp_s)
        begin
          d.init_n    = 1'b1;
          d.data_drv  = 1'b0;
          d.rsp_valid = 1'b1;
          if (!q.is_wr)
            d.rdata = (q.mode == MODE_FETCH_B) ? pick_byte(data_s, q.a0) : data_s;
          d.st = C_REL;
        end
        else if (q.is_wr && q.cnt == TIMEOUT_LAST)
        begin
          // bus was held unchanged for the whole wait; give up and report
          d.init_n    = 1'b1;
          d.data_drv  = 1'b0;
          d.rsp_valid = 1'b1;
          d.rsp_err   = 1'b1;
          d.st        = C_REL;
        end
        else
          d.cnt = q.cnt + 1'b1;
      end
      C_REL:
      begin
        // mode is held until the responder lets go, so no new cycle overlaps
        if (!rsp_s)
        begin
          d.mode_drv   = 1'b0;
          d.dma_active = 1'b0;
          d.st         = C_IDLE;
        end
      end
      C_DG_SET:
      begin
        d.init_n = 1'b0;
        d.st     = C_DG_WAIT;
      end
      C_DG_WAIT:
      begin
        if (rsp_s)
        begin
          d.addr_n   = ~data_s;
          d.init_n   = 1'b1;
          d.mode_drv = 1'b0;
          d.cnt      = '0;
          d.st       = C_DG_ADDR;
        end
      end
      C_DG_ADDR:
      begin
        if (rsp_s)
          d.cnt = '0;
        else if (q.cnt == DSET_LAST)
        begin
          d.init_n = 1'b0;
          d.st     = C_DG_XFER;
        end
        else
          d.cnt = q.cnt + 1'b1;
      end
      C_DG_XFER:
      begin
        if (rsp_s)
        begin
          d.grant_n = 1'b1;
          d.init_n  = 1'b1;
          d.st      = C_REL;
        end
      end
      C_IP_SET:
      begin
        d.init_n = 1'b0;
        d.cnt    = '0;
        d.st     = C_IP_WAIT;
      end
      C_IP_WAIT:
      begin
        if (q.cnt == POLL_LAST)
        begin
          d.init_n = 1'b1;
          d.st     = C_REL;
          if (|data_s[IRQ_BITS-1:0])
          begin
            d.irq_valid  = 1'b1;
            d.irq_serial = 1'b0;
            d.irq_bit    = top_bit(data_s[IRQ_BITS-1:0]);
          end
        end
        else
          d.cnt = q.cnt + 1'b1;
      end
      default:
        d = RST_VAL;
    endcase

    // ready is only offered when nothing of higher rank was waiting last cycle
    d.cmd_ready = (d.st == C_IDLE) && !req_s && !d.eoi_pend;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      q <= RST_VAL;
    else
      q <= d;
  end

  //////////////////////////////////////////////////////////////////////////////
  assign bus.io_address_lines_n = q.addr_n;
  assign bus.init_n             = q.init_n;
  assign bus.dma_bus_grant_n    = q.grant_n;
  assign bus.cpu_data_o         = q.wdata_n;
  assign bus.cpu_data_oe        = {DATA_W{q.data_drv}};
  assign bus.cpu_mode_o         = q.mode;
  assign bus.cpu_mode_oe        = {MODE_W{q.mode_drv}};

  assign cmd_ready  = q.cmd_ready;
  assign rsp_valid  = q.rsp_valid;
  assign rsp_err    = q.rsp_err;
  assign rsp_rdata  = q.rdata;
  assign irq_valid  = q.irq_valid;
  assign irq_serial = q.irq_serial;
  assign irq_level  = q.irq_level;
  assign irq_bit    = q.irq_bit;
  assign dma_active = q.dma_active;

endmodule : paio_master

/* File: hw/paio_peripheral.sv */
// Purpose: peripheral end: memory target, dma requester and interrupt source
// Assumes: last device in the dma chain; bus inputs pass two flip-flops
// Notes:   never answers its own dma transfer; another memory must
`timescale 1ns/10ps
module paio_peripheral
  import paio_pkg::*;
#(
  parameter logic [ADDR_W-1:0] BASE_ADDR = 16'h0000,
  parameter int unsigned       DEPTH     = 64,
  parameter logic [1:0]        IRQ_LEVEL = 2'h0,
  parameter logic [2:0]        IRQ_BIT   = 3'h0
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              dma_start,
  input  wire logic              dma_write,
  input  wire logic              dma_byte,
  input  wire logic [ADDR_W-1:0] dma_addr,
  input  wire logic [DATA_W-1:0] dma_wdata,
  output logic                   dma_busy,
  output logic                   dma_done,
  output logic [DATA_W-1:0]      dma_rdata,
  input  wire logic              irq_raise,
  output logic                   irq_pending,
  paio_if.dev                    bus
);

  localparam int unsigned IDX_W = $clog2(DEPTH);

  typedef enum logic [7:0] {
    D_IDLE = 8'h01,
    D_RSP  = 8'h02,
    D_ACK  = 8'h04,
    D_POLL = 8'h08,
    D_DA   = 8'h10,
    D_DAW  = 8'h20,
    D_DX   = 8'h40,
    D_DXE  = 8'h80
  } dev_st_t;

  typedef struct packed {
    dev_st_t           st;
    logic [ADDR_W-1:0] a1;
    logic [ADDR_W-1:0] a2;
    logic [MODE_W-1:0] m1;
    logic [MODE_W-1:0] m2;
    logic [DATA_W-1:0] d1;
    logic [DATA_W-1:0] d2;
    logic              n1;
    logic              n2;
    logic              g1;
    logic              g2;
    logic              r1;
    logic              r2;
    logic [DATA_W-1:0] dval_n;
    logic              data_drv;
    logic [MODE_W-1:0] mval;
    logic              mode_drv;
    logic              rsp;
    logic              req;
    logic              irq_pend;
    logic              busy;
    logic              wr;
    logic              byt;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              done;
    logic [DATA_W-1:0] rdata;
  } dev_reg_t;

  localparam dev_reg_t RST_VAL = '{
    st: D_IDLE, a1: '1, a2: '1, m1: '1, m2: '1, d1: '1, d2: '1,
    n1: 1'b1, n2: 1'b1, g1: 1'b1, g2: 1'b1, r1: 1'b1, r2: 1'b1, dval_n: '1,
    mval: '1, default: '0
  };

  dev_reg_t          q;
  dev_reg_t          d;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] a_s;
  logic [DATA_W-1:0] data_s;
  logic              init_s;
  logic              grant_s;
  logic              rsp_s;
  logic [ADDR_W-1:0] off;
  logic              hit;
  logic [IDX_W-1:0]  idx;
  logic              we;

  assign a_s     = ~q.a2;
  assign data_s  = ~q.d2;
  assign init_s  = ~q.n2;
  assign grant_s = ~q.g2;
  assign rsp_s   = ~q.r2;
  assign off     = (a_s - BASE_ADDR) >> 1;
  assign hit     = (a_s >= BASE_ADDR) && (off < ADDR_W'(DEPTH));
  assign idx     = off[IDX_W-1:0];
  assign we      = (q.st == D_IDLE) && init_s && !is_poll(q.m2) && hit && is_store(q.m2);

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    d = q;
    d.a1 = bus.io_address_lines_n;
    d.a2 = q.a1;
    d.m1 = bus.mode_lines;
    d.m2 = q.m1;
    d.d1 = bus.io_data_lines_n;
    d.d2 = q.d1;
    d.n1 = bus.init_n;
    d.n2 = q.n1;
    d.g1 = bus.dma_bus_grant_n;
    d.g2 = q.g1;
    d.r1 = bus.xfer_response_n;
    d.r2 = q.r1;
    d.done = 1'b0;
    d.irq_pend = q.irq_pend | irq_raise;

    if (dma_start && !q.busy)
    begin
      d.busy  = 1'b1;
      d.req   = 1'b1;
      d.wr    = dma_write;
      d.byt   = dma_byte;
      d.addr  = dma_addr;
      d.wdata = dma_byte ? {8'h00, dma_wdata[7:0]} : dma_wdata;
    end

    case (q.st)
      D_IDLE:
      begin
        if (init_s && is_poll(q.m2))
        begin
          if (grant_s && q.m2 == MODE_POLL0 && q.req)
          begin
            d.dval_n   = ~q.addr;
            d.data_drv = 1'b1;
            d.st       = D_DA;
          end
          else if (!grant_s && q.m2 == poll_code(IRQ_LEVEL) && q.irq_pend)
          begin
            d.dval_n   = ~(DATA_W'(1) << IRQ_BIT);
            d.data_drv = 1'b1;
            d.st       = D_POLL;
          end
        end
        else if (init_s && hit)
        begin
          if (!is_store(q.m2))
          begin
            d.dval_n   = ~mem[idx];
            d.data_drv = 1'b1;
          end
          d.st = D_RSP;
        end
      end
      D_RSP:
      begin
        // response follows the data by a cycle so the data is settled first
        d.rsp = 1'b1;
        d.st  = D_ACK;
      end
      D_ACK:
      begin
        if (!init_s)
        begin
          d.rsp      = 1'b0;
          d.data_drv = 1'b0;
          d.st       = D_IDLE;
        end
      end
      D_POLL:
      begin
        if (!init_s)
        begin
          d.data_drv = 1'b0;
          d.irq_pend = irq_raise;
          d.st       = D_IDLE;
        end
      end
      D_DA:
      begin
        d.rsp = 1'b1;
        d.st  = D_DAW;
      end
      D_DAW:
      begin
        if (!init_s)
        begin
          d.rsp      = 1'b0;
          d.req      = 1'b0;
          d.mval     = xfer_code(q.wr, q.byt);
          d.mode_drv = 1'b1;
          d.dval_n   = ~q.wdata;
          d.data_drv = q.wr;
          d.st       = D_DX;
        end
      end
      D_DX:
      begin
        if (init_s && rsp_s)
        begin
          d.done  = 1'b1;
          d.rdata = q.byt ? pick_byte(data_s, q.addr[0]) : data_s;
          d.st    = D_DXE;
        end
      end
      D_DXE:
      begin
        if (!init_s)
        begin
          d.mode_drv = 1'b0;
          d.data_drv = 1'b0;
          d.busy     = 1'b0;
          d.st       = D_IDLE;
        end
      end
      default:
        d = RST_VAL;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      q <= RST_VAL;
    else
      q <= d;
  end

  // memory content has no reset; a byte store leaves the other lane alone
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      if (!is_byte(q.m2))
        mem[idx] <= data_s;
      else if (a_s[0])
        mem[idx][15:8] <= data_s[7:0];
      else
        mem[idx][7:0] <= data_s[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign bus.dev_data_o  = q.dval_n;
  assign bus.dev_data_oe = {DATA_W{q.data_drv}};
  assign bus.dev_mode_o  = q.mval;
  assign bus.dev_mode_oe = {MODE_W{q.mode_drv}};
  assign bus.dev_rsp_o   = 1'b0;
  assign bus.dev_rsp_oe  = q.rsp;
  assign bus.dev_req_o   = 1'b0;
  assign bus.dev_req_oe  = q.req;
  assign bus.dev_irq_o   = '0;
  assign bus.dev_irq_oe  = {IRQ_LEVELS{q.irq_pend}} & (4'h1 << IRQ_LEVEL);

  assign dma_busy    = q.busy;
  assign dma_done    = q.done;
  assign dma_rdata   = q.rdata;
  assign irq_pending = q.irq_pend;

endmodule : paio_peripheral

/* File: hw/paio_pkg.sv */
// Purpose: shared constants, mode codes and helpers for the parallel async i/o bus
// Assumes: 125 MHz clk, all bus lines active low except the encoded mode lines
// Notes:   mode codes are a local assignment shared by both ends
package paio_pkg;

  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned BYTE_W        = 8;
  localparam int unsigned MODE_W        = 3;
  localparam int unsigned IRQ_LEVELS    = 4;
  localparam int unsigned IRQ_BITS      = 8;
  localparam int unsigned CNT_W         = 11;

  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned NS_PER_US     = 1000;
  // a stalled store is abandoned after this long (longest time, rounded down)
  localparam int unsigned STORE_TIMEOUT_US  = 10;
  localparam int unsigned STORE_TIMEOUT_CYC = STORE_TIMEOUT_US * NS_PER_US / CLK_PERIOD_NS;
  // time the poll window stays open before the processor samples the data lines
  localparam int unsigned POLL_WINDOW_NS  = 400;
  localparam int unsigned POLL_WINDOW_CYC = POLL_WINDOW_NS / CLK_PERIOD_NS;
  // least time the dma master gets to drive mode and data before reinit
  localparam int unsigned DMA_SETUP_NS  = 80;
  localparam int unsigned DMA_SETUP_CYC = (DMA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // mode code table, as electrical levels on the mode lines (H = 1)
  localparam logic [MODE_W-1:0] MODE_POLL0   = 3'h0;
  localparam logic [MODE_W-1:0] MODE_FETCH_W = 3'h4;
  localparam logic [MODE_W-1:0] MODE_FETCH_B = 3'h5;
  localparam logic [MODE_W-1:0] MODE_STORE_W = 3'h6;
  localparam logic [MODE_W-1:0] MODE_STORE_B = 3'h7;

  function automatic logic [MODE_W-1:0] poll_code(input logic [1:0] lvl);
    poll_code = {1'b0, lvl};
  endfunction : poll_code

  function automatic logic is_poll(input logic [MODE_W-1:0] m);
    is_poll = ~m[2];
  endfunction : is_poll

  function automatic logic is_store(input logic [MODE_W-1:0] m);
    is_store = m[2] & m[1];
  endfunction : is_store

  function automatic logic is_byte(input logic [MODE_W-1:0] m);
    is_byte = m[2] & m[0];
  endfunction : is_byte

  function automatic logic [MODE_W-1:0] xfer_code(input logic wr, input logic byt);
    xfer_code = wr ? (byt ? MODE_STORE_B : MODE_STORE_W) : (byt ? MODE_FETCH_B : MODE_FETCH_W);
  endfunction : xfer_code

  // addressed byte lands in the low byte; even address is the low lane
  function automatic logic [DATA_W-1:0] pick_byte(input logic [DATA_W-1:0] w, input logic a0);
    pick_byte = a0 ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
  endfunction : pick_byte

  function automatic logic [1:0] top_level(input logic [IRQ_LEVELS-1:0] v);
    top_level = 2'h0;
    for (int i = 0; i < IRQ_LEVELS; i++)
      if (v[i]) top_level = 2'(i);
  endfunction : top_level

  function automatic logic [2:0] top_bit(input logic [IRQ_BITS-1:0] v);
    top_bit = 3'h0;
    for (int i = 0; i < IRQ_BITS; i++)
      if (v[i]) top_bit = 3'(i);
  endfunction : top_bit

endpackage : paio_pkg

/* File: tb/paio_chk.sv */
// Purpose: bus-side checks between the two ends
// Assumes: one clock, rst synchronous active high
// Notes:   poll checks skip grant-low cycles, which belong to dma
`timescale 1ns/10ps
module paio_chk
  import paio_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              init_n,
  input wire logic              dma_bus_grant_n,
  input wire logic [ADDR_W-1:0] io_address_lines_n,
  input wire logic [DATA_W-1:0] io_data_lines_n,
  input wire logic [MODE_W-1:0] mode_lines,
  input wire logic              xfer_response_n,
  input wire logic [3:0]        irq_level_lines_n,
  input wire logic [DATA_W-1:0] dev_data_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  int lo_q;
  // run length of init; only unanswered stores may get near the limit
  always_ff @(posedge clk) lo_q <= (rst || init_n) ? 0 : lo_q + 1;
  ////////////////////////////////////////////////////////////
  addr_setup_a: assert property ($fell(init_n) |-> $stable(io_address_lines_n)
    && $stable(mode_lines)) else $error("address or mode moved at init");
  store_data_a: assert property ($fell(init_n) && mode_lines[2:1] == 2'h3
    |-> $stable(io_data_lines_n)) else $error("store data moved at init");
  bus_hold_a: assert property (!init_n && !$past(init_n) |->
    $stable(io_address_lines_n) && $stable(mode_lines)) else $error("bus moved in cycle");
  init_limit_a: assert property (lo_q <= STORE_TIMEOUT_CYC)
    else $error("init held too long");
  rsp_drop_a: assert property (!init_n && !xfer_response_n |-> ##[1:4] init_n)
    else $error("init not dropped after response");
  data_free_a: assert property ($rose(init_n) |-> ##[1:4] dev_data_oe == '0)
    else $error("device kept data lines");
  rsp_free_a: assert property ($rose(init_n) |-> ##[1:4] xfer_response_n)
    else $error("response not released");
  rsp_data_a: assert property ($fell(xfer_response_n) && mode_lines[2:1] == 2'h2
    |-> dev_data_oe != '0) else $error("response without data");
  byte_hi_a: assert property (!init_n && mode_lines == MODE_STORE_B
    |-> io_data_lines_n[15:8] == 8'hFF) else $error("byte store upper lane set");
  poll_top_a: assert property ($fell(init_n) && !mode_lines[2] && dma_bus_grant_n
    |-> (~irq_level_lines_n >> mode_lines[1:0]) == 4'h1) else $error("wrong poll level");
  cover property ($fell(init_n) && mode_lines == MODE_STORE_W);
  cover property ($fell(init_n) && mode_lines == MODE_FETCH_B);
  cover property ($fell(init_n) && !mode_lines[2]);
  cover property ($fell(init_n) && !dma_bus_grant_n && mode_lines[2]);
endmodule : paio_chk

/* File: tb/parallel_async_io_bus_test.sv */
// Purpose: drives both ends through their user ports
// Assumes: peripheral at base 0, 64 words, interrupt level 2 bit 5
// Notes:   dma stops at the transfer; no second memory answers it
`timescale 1ns/10ps
module parallel_async_io_bus_test;
  import paio_pkg::*;
  logic              clk = 1'h0, rst = 1'h1, cmd_valid = 1'h0, cmd_write = 1'h0;
  logic              cmd_byte = 1'h0, end_of_instr = 1'h0, serial_irq_req = 1'h0;
  logic              irq_raise = 1'h0, cmd_ready, rsp_valid, rsp_err, irq_valid, irq_serial;
  logic              irq_pending, dma_active;
  logic              dma_start = 1'h0, dma_write = 1'h0, dma_byte = 1'h0;
  logic [ADDR_W-1:0] cmd_addr = 16'h0000, dma_addr = 16'h0000;
  logic [DATA_W-1:0] cmd_wdata = 16'h0000, rsp_rdata, dma_wdata = 16'h0000;
  logic [1:0]        irq_level;
  logic [2:0]        irq_bit;
  int                fails = 0, num_checks = 0;
  paio_if bus_if ();
  paio_master u_paio_master (.clk, .rst, .cmd_valid, .cmd_write, .cmd_byte, .cmd_addr,
    .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_err, .rsp_rdata, .end_of_instr, .serial_irq_req,
    .irq_valid, .irq_serial, .irq_level, .irq_bit, .dma_active, .bus(bus_if));
  paio_peripheral #(.IRQ_LEVEL(2'h2), .IRQ_BIT(3'h5)) u_paio_peripheral (.clk, .rst,
    .dma_start, .dma_write, .dma_byte, .dma_addr,
    .dma_wdata, .dma_busy(), .dma_done(), .dma_rdata(), .irq_raise, .irq_pending,
    .bus(bus_if));
  paio_chk u_paio_chk (.clk, .rst, .init_n(bus_if.init_n),
    .dma_bus_grant_n(bus_if.dma_bus_grant_n), .io_address_lines_n(bus_if.io_address_lines_n),
    .io_data_lines_n(bus_if.io_data_lines_n), .mode_lines(bus_if.mode_lines),
    .xfer_response_n(bus_if.xfer_response_n), .irq_level_lines_n(bus_if.irq_level_lines_n),
    .dev_data_oe(bus_if.dev_data_oe));
  initial forever #4 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // bounded so a dead handshake falls through to a failing compare
  task automatic wait_hi(ref logic s);
    for (int i = 0; i < 2000 && s !== 1'h1; i++) @(negedge clk);
  endtask : wait_hi
  task automatic pulse(ref logic s);
    s = 1'h1;
    @(negedge clk);
    s = 1'h0;
  endtask : pulse
  task automatic op(input logic w, input logic b, input logic [15:0] a, input logic [15:0] d);
    wait_hi(cmd_ready);
    {cmd_write, cmd_byte, cmd_addr, cmd_wdata} = {w, b, a, d};
    pulse(cmd_valid);
    wait_hi(rsp_valid);
    @(negedge clk);
  endtask : op
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end
  initial
  begin
    repeat (8) @(negedge clk);
    rst = 1'h0;
    op(1'h1, 1'h0, 16'h0010, 16'hA5C3);
    chk({15'h0000, rsp_err}, 16'h0000);
    op(1'h0, 1'h0, 16'h0010, 16'h0000);
    chk(rsp_rdata, 16'hA5C3);
    op(1'h1, 1'h1, 16'h0011, 16'h005A);
    op(1'h0, 1'h0, 16'h0010, 16'h0000);
    chk(rsp_rdata, 16'h5AC3);
    op(1'h0, 1'h1, 16'h0011, 16'h0000);
    chk(rsp_rdata, 16'h005A);
    op(1'h0, 1'h1, 16'h0010, 16'h0000);
    chk(rsp_rdata, 16'h00C3);
    $display("test transfers done");
    // first address past the window must stall the store into the timeout
    op(1'h1, 1'h0, 16'h007E, 16'h1234);
    op(1'h1, 1'h0, 16'h0080, 16'h4321);
    chk({15'h0000, rsp_err}, 16'h0001);
    op(1'h0, 1'h0, 16'h007E, 16'h0000);
    chk(rsp_rdata, 16'h1234);
    chk({15'h0000, rsp_err}, 16'h0000);
    $display("test window and timeout done");
    serial_irq_req = 1'h1;
    pulse(irq_raise);
    repeat (4) @(negedge clk);
    chk({12'h000, bus_if.irq_level_lines_n}, 16'h000B);
    pulse(end_of_instr);
    wait_hi(irq_valid);
    chk({10'h000, irq_serial, irq_level, irq_bit}, 16'h0015);
    repeat (10) @(negedge clk);
    chk({15'h0000, irq_pending}, 16'h0000);
    pulse(end_of_instr);
    wait_hi(irq_valid);
    chk({15'h0000, irq_serial}, 16'h0001);
    $display("test interrupts done");
    // dma fetch: nothing answers the transfer, so the run ends with init held
    {dma_write, dma_byte, dma_addr} = {1'h0, 1'h0, 16'h0022};
    pulse(dma_start);
    wait_hi(dma_active);
    chk({15'h0000, dma_active}, 16'h0001);
    repeat (40) @(negedge clk);
    chk(bus_if.io_address_lines_n, 16'hFFDD);
    chk({13'h0000, dma_active, bus_if.dma_bus_grant_n, bus_if.init_n}, 16'h0004);
    chk({13'h0000, bus_if.mode_lines}, {13'h0000, MODE_FETCH_W});
    $display("test dma done");
    end_of_test();
  end
endmodule : parallel_async_io_bus_test
